// ===== hdl/e1_sa_si_ssm_map.vh
// register map, field positions and counts of the e1 spare/international bit access block
`ifndef E1_SA_SI_SSM_MAP_VH
`define E1_SA_SI_SSM_MAP_VH

`define FES_ADDR 8'h1A
`define MEM_ADDR 8'h1B
`define SCS_ADDR 8'h21
`define SCM_ADDR 8'h22
`define TX_BASE_ADDR 8'h42
`define TX_CTL_ADDR 8'h4A
`define SSM_CTL_ADDR 8'h4B
`define SSM_RX_ADDR 8'h4C
`define RX_BASE_ADDR 8'h58

`define EV_RAF 0
`define EV_RX_CRC4_MULTIFRAME_EVENT 1
`define EV_RMF 2
`define EV_TAF 3
`define EV_TMF 4
`define EV_RX_SIGNALING_ALL_ZEROS 5
`define EV_RX_SIGNALING_ALL_ONES 6

`define MEM_MASK 8'h7F
`define SCM_MASK 8'h1F
`define REG_RESET 8'h00

`define SSM_MATCH_COUNT 2'h3
`define SSM_SEL_MAX 3'h4
`define LAST_FRAME 4'hF
`define FIFO_WIDTH 12
`define FIFO_DEPTH 16
`define FIFO_AW 4

`endif

// ===== hdl/sa_frame_fifo.v
// small synchronous fifo with a registered read stage
`timescale 1ns/1ps
module sa_frame_fifo #(
  parameter WIDTH = 12,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  // clock, reset, enable
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  // fill side
  input wire in_valid_i,
  input wire [WIDTH-1:0] in_data_i,
  output wire in_ready_o,
  // drain side
  output reg out_valid_o,
  output reg [WIDTH-1:0] out_data_o,
  input wire out_ready_i
);

  localparam [AW:0] FULL = DEPTH[AW:0];

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_reg;
  reg [AW-1:0] rd_ptr_reg;
  reg [AW:0] count_reg;
  wire push;
  wire load;

  assign in_ready_o = (count_reg != FULL);
  assign push = in_valid_i && in_ready_o;
  assign load = (count_reg != {(AW+1){1'b0}}) && (!out_valid_o || out_ready_i);

  always @(posedge clk_i)
  begin
    if (ce_i && push)
    begin
      mem[wr_ptr_reg] <= in_data_i;
    end
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
      out_valid_o <= 1'b0;
      out_data_o <= {WIDTH{1'b0}};
    end
    else if (ce_i)
    begin
      if (push)
      begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (load)
      begin
        out_data_o <= mem[rd_ptr_reg];
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
        out_valid_o <= 1'b1;
      end
      else if (out_ready_i)
      begin
        out_valid_o <= 1'b0;
      end
      case ({push, load})
        2'b10: count_reg <= count_reg + 1'b1;
        2'b01: count_reg <= count_reg - 1'b1;
        default: count_reg <= count_reg;
      endcase
    end
  end

endmodule

// ===== hdl/e1_sa_si_ssm_access.v
// e1 spare and international bit access with quality message handling
`timescale 1ns/1ps
`include "e1_sa_si_ssm_map.vh"
module e1_sa_si_ssm_access (
  // clock, reset, enable
  input wire sys_clk_i,
  input wire rst_i,
  input wire ce_i,
  // host register port
  input wire [7:0] reg_addr_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [7:0] reg_wdata_i,
  output reg [7:0] reg_rdata_o,
  // line framer, timeslot 0 streams and frame events
  input wire link_clk_i,
  input wire rx_ts0_bit_i,
  input wire rx_mf_sync_i,
  input wire tx_ts0_bit_i,
  input wire tx_mf_sync_i,
  input wire rx_cas_mf_i,
  input wire rx_sig_zeros_i,
  input wire rx_sig_ones_i,
  output reg tx_ts0_bit_o,
  // interrupt
  output reg irq_o
);

  // bit slot inside a register for a given frame: earliest frame lands in bit 7
  function [2:0] mf_slot;
    input [3:0] frame;
    begin
      mf_slot = 3'h7 - frame[3:1];
    end
  endfunction

  // spare bit of a timeslot 0 byte; bit 7 of the byte is the first bit on the line
  function sa_pick;
    input [7:0] b;
    input [2:0] sel;
    begin
      case (sel)
        3'h0: sa_pick = b[4];
        3'h1: sa_pick = b[3];
        3'h2: sa_pick = b[2];
        3'h3: sa_pick = b[1];
        default: sa_pick = b[0];
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and link clock edge
  reg [7:0] sync1_reg;
  reg [7:0] sync2_reg;
  reg [7:0] sync3_reg;
  wire lk_rise;
  wire rx_bit;
  wire rx_mf;
  wire tx_bit;
  wire tx_mf;
  wire [2:0] ev_rise;

  always @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      sync1_reg <= 8'h00;
      sync2_reg <= 8'h00;
      sync3_reg <= 8'h00;
    end
    else if (ce_i)
    begin
      sync1_reg <= {rx_sig_ones_i, rx_sig_zeros_i, rx_cas_mf_i, tx_mf_sync_i,
                    tx_ts0_bit_i, rx_mf_sync_i, rx_ts0_bit_i, link_clk_i};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  assign lk_rise = sync2_reg[0] && !sync3_reg[0];
  assign rx_bit = sync2_reg[1];
  assign rx_mf = sync2_reg[2];
  assign tx_bit = sync2_reg[3];
  assign tx_mf = sync2_reg[4];
  assign ev_rise = sync2_reg[7:5] & ~sync3_reg[7:5];

  ////////////////////////////////////////////////////////////////////////////
  // receive deserialiser: one fifo word per frame, {frame, byte}
  reg [6:0] rx_cnt_reg;
  reg [6:0] rx_byte_reg;
  reg in_valid_reg;
  reg [11:0] in_data_reg;
  reg overrun_reg;
  wire [6:0] rx_pos;
  wire in_ready;
  wire out_valid;
  wire [11:0] out_data;
  wire out_ready;

  assign rx_pos = rx_mf ? 7'h00 : rx_cnt_reg + 7'h01;

  always @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      rx_cnt_reg <= 7'h7F;
      rx_byte_reg <= 7'h00;
      in_valid_reg <= 1'b0;
      in_data_reg <= 12'h000;
      overrun_reg <= 1'b0;
    end
    else if (ce_i)
    begin
      if (in_valid_reg && in_ready)
      begin
        in_valid_reg <= 1'b0;
      end
      if (lk_rise)
      begin
        rx_cnt_reg <= rx_pos;
        rx_byte_reg <= {rx_byte_reg[5:0], rx_bit};
        if (rx_pos[2:0] == 3'h7)
        begin
          // a word still waiting for room is overwritten; overrun records the loss
          if (in_valid_reg && !in_ready)
          begin
            overrun_reg <= 1'b1;
          end
          in_valid_reg <= 1'b1;
          in_data_reg <= {rx_pos[6:3], rx_byte_reg, rx_bit};
        end
      end
    end
  end

  // draining pauses during a host read so a register set never changes mid-read
  assign out_ready = !reg_rd_i;

  sa_frame_fifo #(
    .WIDTH(`FIFO_WIDTH),
    .DEPTH(`FIFO_DEPTH),
    .AW(`FIFO_AW)
  ) frame_fifo (
    .clk_i(sys_clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .in_valid_i(in_valid_reg),
    .in_data_i(in_data_reg),
    .in_ready_o(in_ready),
    .out_valid_o(out_valid),
    .out_data_o(out_data),
    .out_ready_i(out_ready)
  );

  ////////////////////////////////////////////////////////////////////////////
  // receive registers, change detection and quality message validation
  reg [7:0] rx_sh_reg [0:7];
  reg [7:0] rx_reg [0:7];
  reg [2:0] ssm_shift_reg;
  reg [3:0] ssm_last_reg;
  reg [1:0] ssm_cnt_reg;
  reg [3:0] ssm_valid_msg_reg;
  reg ssm_valid_reg;
  reg [7:0] ssm_ctl_reg;
  reg [4:0] cos_set;
  reg [7:0] commit [0:7];
  wire fire;
  wire [3:0] fr;
  wire [7:0] fb;
  wire [2:0] slot;
  wire [3:0] ssm_msg;
  // one loop index per process, so that no index has two drivers
  integer i;
  integer j;
  integer k;
  integer m;

  assign fire = out_valid && out_ready;
  assign fr = out_data[11:8];
  assign fb = out_data[7:0];
  assign slot = mf_slot(fr);
  assign ssm_msg = {ssm_shift_reg, sa_pick(fb, ssm_ctl_reg[2:0])};

  always @*
  begin
    for (i = 0; i < 8; i = i + 1)
    begin
      commit[i] = rx_sh_reg[i];
    end
    commit[1] = {rx_sh_reg[1][7:1], fb[7]};
    commit[2] = {rx_sh_reg[2][7:1], fb[5]};
    for (i = 0; i < 5; i = i + 1)
    begin
      commit[3 + i] = {rx_sh_reg[3 + i][7:1], fb[4 - i]};
    end
    cos_set = 5'h00;
    if (fire && fr == `LAST_FRAME)
    begin
      for (i = 0; i < 5; i = i + 1)
      begin
        cos_set[i] = (commit[3 + i] != rx_reg[3 + i]);
      end
    end
  end

  always @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      for (j = 0; j < 8; j = j + 1)
      begin
        rx_sh_reg[j] <= `REG_RESET;
        rx_reg[j] <= `REG_RESET;
      end
      ssm_shift_reg <= 3'h0;
      ssm_last_reg <= 4'h0;
      ssm_cnt_reg <= 2'h0;
      ssm_valid_msg_reg <= 4'h0;
      ssm_valid_reg <= 1'b0;
    end
    else if (ce_i && fire)
    begin
      if (!fr[0])
      begin
        rx_sh_reg[0][slot] <= fb[7];
      end
      else
      begin
        rx_sh_reg[1][slot] <= fb[7];
        rx_sh_reg[2][slot] <= fb[5];
        for (j = 0; j < 5; j = j + 1)
        begin
          rx_sh_reg[3 + j][slot] <= fb[4 - j];
        end
        ssm_shift_reg <= ssm_msg[2:0];
        // odd frames 7 and 15 close a half-multiframe
        if (fr[2:0] == 3'h7)
        begin
          ssm_last_reg <= ssm_msg;
          if (ssm_msg == ssm_last_reg && ssm_cnt_reg != `SSM_MATCH_COUNT)
          begin
            ssm_cnt_reg <= ssm_cnt_reg + 2'h1;
          end
          else if (ssm_msg != ssm_last_reg)
          begin
            ssm_cnt_reg <= 2'h1;
          end
          if ((ssm_msg == ssm_last_reg) && (ssm_cnt_reg >= 2'h2))
          begin
            ssm_valid_msg_reg <= ssm_msg;
            ssm_valid_reg <= 1'b1;
          end
        end
      end
      if (fr == `LAST_FRAME)
      begin
        for (j = 0; j < 8; j = j + 1)
        begin
          rx_reg[j] <= commit[j];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmit insertion
  reg [6:0] tx_cnt_reg;
  reg [7:0] tx_sh_reg [0:7];
  reg [7:0] tx_reg [0:7];
  reg [7:0] tx_ctl_reg;
  reg tx_out;
  wire [6:0] tx_pos;
  wire [2:0] tx_slot;
  wire [2:0] tx_p;

  assign tx_pos = tx_mf ? 7'h00 : tx_cnt_reg + 7'h01;
  assign tx_slot = mf_slot(tx_pos[6:3]);
  assign tx_p = tx_pos[2:0];

  always @*
  begin
    tx_out = tx_bit;
    if (!tx_pos[3])
    begin
      if (tx_p == 3'h0 && tx_ctl_reg[0])
      begin
        // the first bit goes out in the same cycle as the sample, so read the live copy
        tx_out = (tx_pos == 7'h00) ? tx_reg[0][7] : tx_sh_reg[0][tx_slot];
      end
    end
    else if (tx_p == 3'h0)
    begin
      tx_out = tx_ctl_reg[1] ? tx_sh_reg[1][tx_slot] : tx_bit;
    end
    else if (tx_p == 3'h2)
    begin
      tx_out = tx_ctl_reg[2] ? tx_sh_reg[2][tx_slot] : tx_bit;
    end
    else if (tx_p >= 3'h3)
    begin
      if (ssm_ctl_reg[3] && (tx_p - 3'h3) == ssm_ctl_reg[2:0])
      begin
        tx_out = ssm_ctl_reg[4 + (3 - tx_pos[5:4])];
      end
      else if (tx_ctl_reg[tx_p])
      begin
        tx_out = tx_sh_reg[tx_p][tx_slot];
      end
    end
  end

  always @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      tx_cnt_reg <= 7'h7F;
      tx_ts0_bit_o <= 1'b0;
      for (k = 0; k < 8; k = k + 1)
      begin
        tx_sh_reg[k] <= `REG_RESET;
      end
    end
    else if (ce_i && lk_rise)
    begin
      tx_cnt_reg <= tx_pos;
      tx_ts0_bit_o <= tx_out;
      if (tx_pos == 7'h00)
      begin
        for (k = 0; k < 8; k = k + 1)
        begin
          tx_sh_reg[k] <= tx_reg[k];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // host registers, latched status and interrupt
  reg [7:0] fes_reg;
  reg [7:0] mem_reg;
  reg [7:0] scs_reg;
  reg [7:0] scm_reg;
  reg [7:0] ev_set;
  wire [7:0] fes_next;
  wire [7:0] scs_next;
  wire wr_fes;
  wire wr_scs;

  always @*
  begin
    ev_set = 8'h00;
    ev_set[`EV_RAF] = lk_rise && rx_pos[2:0] == 3'h0 && !rx_pos[3];
    ev_set[`EV_RX_CRC4_MULTIFRAME_EVENT] = fire && fr == `LAST_FRAME;
    ev_set[`EV_RMF] = ev_rise[0];
    ev_set[`EV_TAF] = lk_rise && tx_p == 3'h0 && !tx_pos[3];
    ev_set[`EV_TMF] = lk_rise && tx_pos == 7'h00;
    ev_set[`EV_RX_SIGNALING_ALL_ZEROS] = ev_rise[1];
    ev_set[`EV_RX_SIGNALING_ALL_ONES] = ev_rise[2];
  end

  assign wr_fes = reg_wr_i && reg_addr_i == `FES_ADDR;
  assign wr_scs = reg_wr_i && reg_addr_i == `SCS_ADDR;
  // a set in the clearing cycle wins
  assign fes_next = (fes_reg & ~(wr_fes ? reg_wdata_i : 8'h00)) | ev_set;
  assign scs_next = (scs_reg & ~(wr_scs ? reg_wdata_i : 8'h00)) | {3'h0, cos_set};

  always @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      fes_reg <= `REG_RESET;
      mem_reg <= `REG_RESET;
      scs_reg <= `REG_RESET;
      scm_reg <= `REG_RESET;
      tx_ctl_reg <= `REG_RESET;
      ssm_ctl_reg <= `REG_RESET;
      reg_rdata_o <= 8'h00;
      irq_o <= 1'b0;
      for (m = 0; m < 8; m = m + 1)
      begin
        tx_reg[m] <= `REG_RESET;
      end
    end
    else if (ce_i)
    begin
      fes_reg <= fes_next;
      scs_reg <= scs_next & `SCM_MASK;
      // mask bits above the documented fields are not stored
      if (reg_wr_i)
      begin
        case (reg_addr_i)
          `MEM_ADDR: mem_reg <= reg_wdata_i & `MEM_MASK;
          `SCM_ADDR: scm_reg <= reg_wdata_i & `SCM_MASK;
          `TX_CTL_ADDR: tx_ctl_reg <= reg_wdata_i;
          `SSM_CTL_ADDR: ssm_ctl_reg <= (reg_wdata_i[2:0] > `SSM_SEL_MAX) ?
                                        {reg_wdata_i[7:3], `SSM_SEL_MAX} : reg_wdata_i;
          default:
          begin
            if (reg_addr_i[7:3] == `TX_BASE_ADDR >> 3 && reg_addr_i[2:0] >= 3'h2)
            begin
              tx_reg[reg_addr_i[2:0] - 3'h2] <= reg_wdata_i;
            end
            else if (reg_addr_i[7:3] == 5'h09 && reg_addr_i[2:0] <= 3'h1)
            begin
              tx_reg[reg_addr_i[2:0] + 3'h6] <= reg_wdata_i;
            end
          end
        endcase
      end
      if (reg_rd_i)
      begin
        if (reg_addr_i[7:3] == `RX_BASE_ADDR >> 3)
        begin
          reg_rdata_o <= rx_reg[reg_addr_i[2:0]];
        end
        else if (reg_addr_i >= `TX_BASE_ADDR && reg_addr_i < `TX_CTL_ADDR)
        begin
          reg_rdata_o <= tx_reg[reg_addr_i[2:0] - 3'h2];
        end
        else
        begin
          case (reg_addr_i)
            `FES_ADDR: reg_rdata_o <= fes_reg;
            `MEM_ADDR: reg_rdata_o <= mem_reg;
            `SCS_ADDR: reg_rdata_o <= scs_reg;
            `SCM_ADDR: reg_rdata_o <= scm_reg;
            `TX_CTL_ADDR: reg_rdata_o <= tx_ctl_reg;
            `SSM_CTL_ADDR: reg_rdata_o <= ssm_ctl_reg;
            `SSM_RX_ADDR: reg_rdata_o <= {overrun_reg, 2'h0, ssm_valid_reg, ssm_valid_msg_reg};
            default: reg_rdata_o <= 8'h00;
          endcase
        end
      end
      irq_o <= |(fes_next & mem_reg) || |(scs_next & scm_reg);
    end
  end

endmodule

// ===== verification/e1_sa_si_ssm_access_monitor.sv
// assertion checker for the e1 spare bit access block, bound to its ports
`timescale 1ns/1ps
module e1_sa_si_ssm_access_monitor (
  // clock, reset, enable
  input wire sys_clk_i,
  input wire rst_i,
  input wire ce_i,
  // host register port
  input wire [7:0] reg_addr_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [7:0] reg_wdata_i,
  input wire [7:0] reg_rdata_o,
  // line side and interrupt
  input wire link_clk_i,
  input wire tx_ts0_bit_o,
  input wire irq_o
);
  reg [6:0] ev_mask_q;
  reg [4:0] ch_mask_q;
  wire rd_ok = reg_rd_i && ce_i;
  // shadow of the mask bits the block is meant to store
  always @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      ev_mask_q <= 7'h00;
      ch_mask_q <= 5'h00;
    end
    else if (ce_i && reg_wr_i)
    begin
      if (reg_addr_i == 8'h1B)
        ev_mask_q <= reg_wdata_i[6:0];
      if (reg_addr_i == 8'h22)
        ch_mask_q <= reg_wdata_i[4:0];
    end
  end
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);
  chk_evmask_readback:
  assert property (rd_ok && reg_addr_i == 8'h1B |=> reg_rdata_o[6:0] == $past(ev_mask_q))
    else $error("event mask readback");
  chk_evmask_top_zero:
  assert property (rd_ok && reg_addr_i == 8'h1B ##1 1'b1 |-> !reg_rdata_o[7])
    else $error("event mask bit 7 set");
  chk_chmask_readback:
  assert property (rd_ok && reg_addr_i == 8'h22 |=> reg_rdata_o[4:0] == $past(ch_mask_q))
    else $error("change mask readback");
  chk_chmask_top_zero:
  assert property (rd_ok && reg_addr_i == 8'h22 |=> reg_rdata_o[7:5] == 3'h0)
    else $error("change mask top bits set");
  chk_chstat_top_zero:
  assert property (rd_ok && reg_addr_i == 8'h21 |=> reg_rdata_o[7:5] == 3'h0)
    else $error("change status top bits set");
  chk_rdata_holds:
  assert property (!rd_ok |=> $stable(reg_rdata_o))
    else $error("read data moved without a read");
  chk_irq_needs_mask:
  assert property (irq_o |-> $past({ev_mask_q, ch_mask_q}) != 12'h000)
    else $error("interrupt with all masks clear");
  chk_tx_bit_timing:
  assert property ($changed(tx_ts0_bit_o) |-> link_clk_i && $past(link_clk_i))
    else $error("line bit changed away from a link clock rise");
  chk_ssm_sel_range:
  assert property (rd_ok && reg_addr_i == 8'h4B |=> reg_rdata_o[2:0] <= 3'h4)
    else $error("message select out of range");
endmodule
bind e1_sa_si_ssm_access e1_sa_si_ssm_access_monitor u_e1_sa_si_ssm_access_monitor (
  .sys_clk_i(sys_clk_i), .rst_i(rst_i), .ce_i(ce_i), .reg_addr_i(reg_addr_i),
  .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
  .reg_rdata_o(reg_rdata_o), .link_clk_i(link_clk_i), .tx_ts0_bit_o(tx_ts0_bit_o),
  .irq_o(irq_o)
);

// ===== verification/e1_line_partner.sv
// behavioural far end: line clock, timeslot 0 streams, capture of the sent stream
`timescale 1ns/1ps
module e1_line_partner (
  // multiframe to send, first line bit in bit 127
  input wire [127:0] rx_mf_i,
  input wire tx_bit_i,
  // line towards the block
  output reg link_clk_o,
  output reg rx_bit_o,
  output reg rx_sync_o,
  output reg tx_bit_o,
  output reg tx_sync_o,
  // last complete multiframe seen from the block
  output reg [127:0] tx_cap_o,
  output reg [15:0] mf_cnt_o
);
  reg [6:0] idx;
  reg [127:0] cap;
  // the e1 line clock runs free; odd start keeps its edges off the bench clock edges
  initial
  begin
    {idx, cap, tx_cap_o, mf_cnt_o} = 0;
    {link_clk_o, rx_bit_o, tx_bit_o} = 3'b000;
    {rx_sync_o, tx_sync_o} = 2'b11;
    #7;
    forever #80 link_clk_o = ~link_clk_o;
  end
  // data moves on the falling edge so it is settled at the rising edge
  always @(negedge link_clk_o)
  begin
    cap[7'd127 - idx] = tx_bit_i;
    if (idx == 7'd127)
    begin
      tx_cap_o = cap;
      mf_cnt_o = mf_cnt_o + 16'h0001;
    end
    idx = idx + 7'd1;
    rx_bit_o = rx_mf_i[7'd127 - idx];
    rx_sync_o = (idx == 7'd0);
    tx_sync_o = (idx == 7'd0);
    // alternating framer bits expose a bit wrongly passed through
    tx_bit_o = idx[0];
  end
endmodule

// ===== verification/test_e1_sa_si_ssm_access.sv
// self-checking bench for the e1 spare and international bit access block
`timescale 1ns/1ps
`include "e1_sa_si_ssm_map.vh"
module test_e1_sa_si_ssm_access;
  localparam [23:0] CODES = 24'hF248B0;
  localparam [47:0] CTLS = 48'hFF55AA0FF03C;
  localparam [63:0] REG_PAT = 64'h963CA511224488F0;
  reg sys_clk = 1'b0;
  reg rst = 1'b1;
  reg ce = 1'b1;
  reg rd = 1'b0;
  reg wr = 1'b0;
  reg cas_mf = 1'b0;
  reg sig_zeros = 1'b0;
  reg sig_ones = 1'b0;
  reg [7:0] addr = 8'h00;
  reg [7:0] wdata = 8'h00;
  reg [127:0] rx_mf = 128'h0;
  wire [7:0] rdata;
  wire irq, tx_out, link_clk, rx_bit, rx_sync, fr_bit, fr_sync;
  wire [127:0] tx_cap;
  wire [15:0] mf_cnt;
  integer num_errors = 0;
  integer check_count = 0;
  integer cyc = 0;
  integer i, b;
  reg [7:0] v, ctl;
  reg [3:0] code;
  reg [2:0] sel;
  reg [63:0] regs;
  reg [127:0] exp_tx;
  e1_sa_si_ssm_access u_e1_sa_si_ssm_access (
    .sys_clk_i(sys_clk), .rst_i(rst), .ce_i(ce), .reg_addr_i(addr), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .link_clk_i(link_clk),
    .rx_ts0_bit_i(rx_bit), .rx_mf_sync_i(rx_sync), .tx_ts0_bit_i(fr_bit),
    .tx_mf_sync_i(fr_sync), .rx_cas_mf_i(cas_mf), .rx_sig_zeros_i(sig_zeros),
    .rx_sig_ones_i(sig_ones), .tx_ts0_bit_o(tx_out), .irq_o(irq)
  );
  e1_line_partner u_e1_line_partner (
    .rx_mf_i(rx_mf), .tx_bit_i(tx_out), .link_clk_o(link_clk), .rx_bit_o(rx_bit),
    .rx_sync_o(rx_sync), .tx_bit_o(fr_bit), .tx_sync_o(fr_sync), .tx_cap_o(tx_cap),
    .mf_cnt_o(mf_cnt)
  );
  always #5 sys_clk = ~sys_clk;
  // the sequence needs some 51000 cycles
  always @(posedge sys_clk)
  begin
    cyc = cyc + 1;
    if (cyc == 90000)
    begin
      num_errors = num_errors + 1;
      end_sim;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // line order of one multiframe; c gates each of the eight registers
  function [127:0] mf_build(input [63:0] r, input [7:0] c, input [127:0] base);
    integer f, k, s;
    begin
      mf_build = base;
      for (f = 0; f < 16; f = f + 1)
        for (k = 0; k < 8; k = k + 1)
        begin
          s = (f % 2 == 0) ? ((k == 0) ? 0 : -1) : ((k == 0) ? 1 : (k == 1) ? -1 : k);
          if (s >= 0 && c[s])
            mf_build[127 - f * 8 - k] = r[63 - s * 8 - f / 2];
        end
    end
  endfunction
  task end_sim;
    begin
      $display("errors %0d checks %0d", num_errors, check_count);
      if (num_errors == 0 && check_count > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  task wr_reg(input [7:0] a, input [7:0] d);
    begin
      @(negedge sys_clk);
      addr = a;
      wdata = d;
      wr = 1'b1;
      @(negedge sys_clk);
      wr = 1'b0;
    end
  endtask
  task rd_reg(input [7:0] a);
    begin
      @(negedge sys_clk);
      addr = a;
      rd = 1'b1;
      @(negedge sys_clk);
      rd = 1'b0;
      @(negedge sys_clk);
      v = rdata;
    end
  endtask
  task chk8(input [7:0] a, input [7:0] e, input [7:0] g);
    begin
      check_count = check_count + 1;
      if (g !== e)
      begin
        num_errors = num_errors + 1;
        $display("MISMATCH reg %h exp %h got %h", a, e, g);
      end
    end
  endtask
  task chk1(input [127:0] nm, input e, input g);
    begin
      check_count = check_count + 1;
      if (g !== e)
      begin
        num_errors = num_errors + 1;
        $display("MISMATCH %0s exp %b got %b", nm, e, g);
      end
    end
  endtask
  task chk128(input [127:0] e, input [127:0] g);
    begin
      check_count = check_count + 1;
      if (g !== e)
      begin
        num_errors = num_errors + 1;
        $display("MISMATCH tx stream exp %h got %h", e, g);
      end
    end
  endtask
  task rd_chk(input [7:0] a, input [7:0] e);
    begin
      rd_reg(a);
      chk8(a, e, v);
    end
  endtask
  task wait_mf(input integer n);
    integer t;
    begin
      t = mf_cnt + n;
      while (mf_cnt < t)
        @(posedge sys_clk);
      // room for the last frame to drain into the registers
      repeat (30) @(posedge sys_clk);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (8) @(negedge sys_clk);
    rst = 1'b0;
    rd_chk(`FES_ADDR, 8'h00);
    rd_chk(`SCS_ADDR, 8'h00);
    rd_chk(`SCM_ADDR, 8'h00);
    rd_chk(`MEM_ADDR, 8'h00);
    // a write while the clock enable is low must leave the mask untouched
    ce = 1'b0;
    wr_reg(`SCM_ADDR, 8'h1F);
    ce = 1'b1;
    rd_chk(`SCM_ADDR, 8'h00);
    wr_reg(8'h00, 8'hA5);
    rd_chk(8'h00, 8'h00);
    // software keeps the unused mask bits at zero
    wr_reg(`SCM_ADDR, 8'h1F);
    rd_chk(`SCM_ADDR, 8'h1F);
    wr_reg(`MEM_ADDR, 8'h7F);
    rd_chk(`MEM_ADDR, 8'h7F);
    // select codes past the last spare bit are held at the last one
    wr_reg(`SSM_CTL_ADDR, 8'h07);
    rd_chk(`SSM_CTL_ADDR, 8'h04);
    wr_reg(`MEM_ADDR, 8'h00);
    wr_reg(`SCM_ADDR, 8'h00);
    // six quality codes, every select, varied insert enables
    for (i = 0; i < 6; i = i + 1)
    begin
      code = CODES[23 - 4 * i -: 4];
      sel = (i == 5) ? 3'd0 : i[2:0];
      ctl = CTLS[47 - 8 * i -: 8] | (8'h08 << sel);
      regs = REG_PAT ^ {8{i[7:0]}};
      for (b = 0; b < 8; b = b + 1)
        wr_reg(`TX_BASE_ADDR + b[7:0], regs[63 - 8 * b -: 8]);
      wr_reg(`TX_CTL_ADDR, ctl);
      wr_reg(`SSM_CTL_ADDR, {code, 1'b1, sel});
      regs[63 - 8 * (3 + sel) -: 8] = {code, code};
      exp_tx = mf_build(regs, ctl, {64{2'b01}});
      rx_mf = mf_build(regs, 8'hFF, 128'h0);
      wait_mf(3);
      chk128(exp_tx, tx_cap);
      rd_chk(`SSM_RX_ADDR, {4'h1, code});
      for (b = 0; b < 8; b = b + 1)
        rd_chk(`RX_BASE_ADDR + b[7:0], regs[63 - 8 * b -: 8]);
      rd_reg(`FES_ADDR);
      chk1("crc4 mf event", 1'b1, v[1]);
      wr_reg(`FES_ADDR, 8'h02);
    end
    // change of state: quiet multiframes, then one flipped spare bit
    wr_reg(`SCS_ADDR, 8'hFF);
    wait_mf(2);
    rd_chk(`SCS_ADDR, 8'h00);
    chk128(exp_tx, tx_cap);
    regs[12] = ~regs[12];
    rx_mf = mf_build(regs, 8'hFF, 128'h0);
    wait_mf(2);
    rd_chk(`SCS_ADDR, 8'h08);
    chk1("irq masked", 1'b0, irq);
    wait_mf(1);
    rd_chk(`SCS_ADDR, 8'h08);
    wr_reg(`SCM_ADDR, 8'h08);
    @(negedge sys_clk);
    chk1("irq change", 1'b1, irq);
    wr_reg(`SCM_ADDR, 8'h17);
    @(negedge sys_clk);
    chk1("irq change", 1'b0, irq);
    wr_reg(`SCS_ADDR, 8'h08);
    rd_chk(`SCS_ADDR, 8'h00);
    wr_reg(`SCM_ADDR, 8'h00);
    // event masks one at a time
    {cas_mf, sig_zeros, sig_ones} = 3'b111;
    repeat (8) @(negedge sys_clk);
    {cas_mf, sig_zeros, sig_ones} = 3'b000;
    rd_chk(`FES_ADDR, 8'h7F);
    for (b = 0; b < 7; b = b + 1)
    begin
      wr_reg(`MEM_ADDR, 8'h01 << b);
      @(negedge sys_clk);
      chk1("irq event", 1'b1, irq);
      wr_reg(`FES_ADDR, 8'h01 << b);
      @(negedge sys_clk);
      if (b == 2 || b > 4)
        chk1("irq event", 1'b0, irq);
    end
    wr_reg(`MEM_ADDR, 8'h00);
    // a held read stops the drain until the fifo overflows
    @(negedge sys_clk);
    addr = `FES_ADDR;
    rd = 1'b1;
    repeat (3200) @(negedge sys_clk);
    rd = 1'b0;
    wait_mf(1);
    rd_reg(`SSM_RX_ADDR);
    chk1("fifo overrun", 1'b1, v[7]);
    end_sim;
  end
endmodule
